/* rtl/qaw_watchdog.sv */
module qaw_watchdog
   import qaw_pkg::*;
#(
   parameter int CYCLES_PER_MS = QAW_CYCLES_PER_MS
) (
   // Core clock, reset, enable
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   // Register link
   input wire logic spi_sclk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_mosi_in,
   output logic spi_miso_out,
   // Failure actions
   output logic fail_flag_out,
   output logic fail_reset_out
);

   qaw_state_t state_r, state_nxt;
   logic link_rst_r;
   logic [15:0] frame;
   logic frame_done;
   logic done_s1_r, done_s2_r, done_s3_r;
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] setup_a_r, rst_width_r, chal_setup_r;
   logic [2:0] timer_sel_r;
   logic [3:0] question_r, question_nxt;
   logic [1:0] idx_r;
   logic bad_r, last_bad_r;
   logic [3:0] err_r, err_nxt, err_inc, thr;
   logic fail_r;
   logic [7:0] rst_cnt_r;
   logic [15:0] tick_cnt_r;
   logic [14:0] ms_cnt_r;

   // Link endpoint in the serial clock domain
   qaw_spi_link u_link (
      .spi_sclk_in(spi_sclk_in),
      .spi_cs_n_in(spi_cs_n_in),
      .spi_mosi_in(spi_mosi_in),
      .spi_miso_out(spi_miso_out),
      .link_rst_in(link_rst_r),
      .rdata_in(rdata_r),
      .frame_out(frame),
      .frame_done_out(frame_done)
   );

   // Reset for the link domain and done-level synchroniser
   always_ff @(posedge clk_in) begin
      link_rst_r <= srst_in;
      if (srst_in) begin
         done_s1_r <= 1'b0;
         done_s2_r <= 1'b0;
         done_s3_r <= 1'b0;
      end else begin
         done_s1_r <= frame_done;
         done_s2_r <= done_s1_r;
         done_s3_r <= done_s2_r;
      end
   end

   // Transfer decode; frame is stable while the done level stands
   logic frame_ev, wr, rd;
   logic [6:0] addr;
   logic [7:0] wdata;
   assign frame_ev = done_s2_r & ~done_s3_r;
   assign addr = frame[QAW_FRAME_ADDR_LSB +: 7];
   assign wdata = frame[7:0];
   assign wr = frame_ev & frame[QAW_FRAME_RW_BIT];
   assign rd = frame_ev & ~frame[QAW_FRAME_RW_BIT];

   // Strobes into the watchdog
   logic q_read, ans_wr, kick;
   assign q_read = rd & (addr == QAW_ADDR_CHAL_VALUE);
   assign ans_wr = wr & (addr == QAW_ADDR_RESP_PORT);
   assign kick = wr & (addr == QAW_ADDR_KICK);

   // Period lookup and half-period window length
   logic [1:0] mode, pre, act_sel;
   logic [14:0] period_ms, half_ms;
   logic enabled;
   assign mode = setup_a_r[QAW_MODE_LSB +: 2];
   assign pre = setup_a_r[QAW_PRE_LSB +: 2];
   assign act_sel = setup_a_r[QAW_ACT_FLAG_BIT +: 2];
   assign period_ms = QAW_PERIOD_MS[timer_sel_r][pre];
   assign half_ms = {1'b0, period_ms[14:1]};
   assign enabled = (mode == QAW_MODE_QA) && (half_ms != 15'h0000);

   // Free-running millisecond tick and window timer
   logic ms_tick, window_end;
   assign ms_tick = (tick_cnt_r == 16'(CYCLES_PER_MS - 1));
   assign window_end = ms_tick && (ms_cnt_r == half_ms - 15'h0001);

   // Expected byte and answer classification
   logic [31:0] ans_word;
   logic [7:0] expected;
   logic byte_ok, last, act, good_end, bad_end, ans_last;
   assign ans_word = QAW_ANSWER_TABLE[question_r];
   assign expected = ans_word[{idx_r, 3'b000} +: 8];
   assign byte_ok = (wdata == expected);
   assign last = (idx_r == QAW_IDX_LAST);
   assign act = ce_in & enabled & ~kick;
   assign ans_last = ans_wr & last;
   // Good only for the fourth byte inside window two on a clean run
   assign good_end = act & ans_last & (state_r == QAW_WIN2) & ~bad_r & byte_ok;
   // Fourth byte with a fault, or window two running out
   assign bad_end = act & ((ans_last & ~good_end)
                    | ((state_r == QAW_WIN2) & window_end & ~ans_last));

   // Error counter with saturation at zero, and threshold
   logic fire;
   assign err_inc = err_r + 4'h1;
   assign thr = (setup_a_r[QAW_THR_LSB +: 2] == 2'h0) ? QAW_THR_1 :
                (setup_a_r[QAW_THR_LSB +: 2] == 2'h1) ? QAW_THR_5 : QAW_THR_9;
   assign fire = bad_end & (err_inc >= thr);
   assign err_nxt = fire ? 4'h0 :
                    bad_end ? err_inc :
                    (good_end && err_r != 4'h0) ? err_r - 4'h1 : err_r;

   // Chain step: zero goes to one, else shift with feedback
   logic [3:0] chain_next;
   assign chain_next = (question_r == 4'h0) ? 4'h1 :
                       {question_r[2:0], question_r[3] ^ question_r[2]};
   assign question_nxt = good_end ? chain_next : question_r;

   // Cycle sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         QAW_IDLE: begin
            if (q_read || ans_wr) begin
               state_nxt = QAW_WIN1;
            end
         end
         QAW_WIN1: begin
            if (ans_last) begin
               state_nxt = QAW_WIN1;
            end else if (window_end) begin
               state_nxt = QAW_WIN2;
            end
         end
         QAW_WIN2: begin
            if (good_end || bad_end) begin
               state_nxt = QAW_WIN1;
            end
         end
         default: begin
            state_nxt = QAW_IDLE;
         end
      endcase
      if (!enabled || kick) begin
         state_nxt = QAW_IDLE;
      end
   end

   // Register read mux; reads have no side effect beyond starting from idle
   always_comb begin
      case (addr)
         QAW_ADDR_SETUP_A: rdata_nxt = setup_a_r;
         QAW_ADDR_SETUP_B: rdata_nxt = {timer_sel_r, 1'b0, err_r};
         QAW_ADDR_RST_WIDTH: rdata_nxt = rst_width_r;
         QAW_ADDR_CHAL_SETUP: rdata_nxt = chal_setup_r;
         QAW_ADDR_CHAL_VALUE: rdata_nxt = {last_bad_r, 1'b0, idx_r, question_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Configuration registers and read data
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         setup_a_r <= QAW_SETUP_A_RST;
         timer_sel_r <= QAW_TIMER_RST;
         rst_width_r <= QAW_RST_WIDTH_RST;
         chal_setup_r <= QAW_CHAL_SETUP_RST;
         rdata_r <= 8'h00;
      end else if (ce_in) begin
         if (wr && addr == QAW_ADDR_SETUP_A) setup_a_r <= wdata;
         if (wr && addr == QAW_ADDR_SETUP_B) timer_sel_r <= wdata[QAW_TIMER_LSB +: 3];
         if (wr && addr == QAW_ADDR_RST_WIDTH) rst_width_r <= wdata;
         if (wr && addr == QAW_ADDR_CHAL_SETUP) chal_setup_r <= wdata;
         if (rd) rdata_r <= rdata_nxt;
      end
   end

   // Timers: tick runs free, window count restarts with each window
   logic win_restart;
   assign win_restart = (state_r != state_nxt) || good_end || bad_end || (state_r == QAW_IDLE);
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         tick_cnt_r <= 16'h0000;
         ms_cnt_r <= 15'h0000;
      end else if (ce_in) begin
         tick_cnt_r <= ms_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
         if (win_restart) begin
            ms_cnt_r <= 15'h0000;
         end else if (ms_tick) begin
            ms_cnt_r <= ms_cnt_r + 15'h0001;
         end
      end
   end

   // Index and fault tracking across one answer run
   logic idx_clear;
   assign idx_clear = good_end || bad_end || kick || !enabled;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_r <= QAW_IDLE;
         idx_r <= QAW_IDX_FIRST;
         bad_r <= 1'b0;
         last_bad_r <= 1'b0;
      end else if (ce_in) begin
         state_r <= state_nxt;
         if (idx_clear) begin
            idx_r <= QAW_IDX_FIRST;
            bad_r <= 1'b0;
         end else if (ans_wr) begin
            idx_r <= idx_r - 2'h1;
            // Wrong byte, or a not-last byte landing in window two
            bad_r <= bad_r | ~byte_ok | (state_r == QAW_WIN2);
         end
         if (good_end || bad_end) last_bad_r <= bad_end;
      end
   end

   // Question, error count and failure actions
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         question_r <= QAW_QUESTION_RST;
         err_r <= 4'h0;
         fail_r <= 1'b0;
         rst_cnt_r <= 8'h00;
      end else if (ce_in) begin
         question_r <= question_nxt;
         err_r <= err_nxt;
         // Set wins over the clear by a kick
         if (fire && act_sel[0]) begin
            fail_r <= 1'b1;
         end else if (kick) begin
            fail_r <= 1'b0;
         end
         if (fire && act_sel[1]) begin
            rst_cnt_r <= (rst_width_r == 8'h00) ? 8'h01 : rst_width_r;
         end else if (ms_tick && rst_cnt_r != 8'h00) begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
         end
      end
   end

   assign fail_flag_out = fail_r;
   assign fail_reset_out = (rst_cnt_r != 8'h00);

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   sequence s_fourth_in_win2;
      (state_r == QAW_WIN2) && ans_last && ce_in && enabled && !kick;
   endsequence

   sequence s_win2_timeout;
      (state_r == QAW_WIN2) && window_end && !ans_last && ce_in && enabled && !kick;
   endsequence

   a_good_new_question: assert property (good_end |=> question_r == $past(chain_next))
      else $error("good answer did not load next question");
   a_bad_same_question: assert property (bad_end |=> question_r == $past(question_r))
      else $error("bad answer changed the question");
   a_bad_counts_up: assert property (bad_end && !fire |=> err_r == $past(err_inc))
      else $error("bad answer did not bump error count");
   a_err_floor_zero: assert property (good_end && err_r == 4'h0 |=> err_r == 4'h0)
      else $error("error count went below zero");
   a_fire_pulse_out: assert property (fire && act_sel[1] |=> fail_reset_out
      ##1 (fail_reset_out || rst_width_r < 8'h02))
      else $error("failure did not raise reset pulse");
   a_zero_goes_one: assert property (good_end && question_r == 4'h0 |=> question_r == 4'h1)
      else $error("zero question did not step to one");
   a_read_starts: assert property ((state_r == QAW_IDLE) && q_read && act |=>
      state_r == QAW_WIN1)
      else $error("question read did not start window one");
   a_window_split: assert property ((state_r == QAW_WIN1) && window_end && act
      && !ans_last |=> state_r == QAW_WIN2 && ms_cnt_r == 15'h0000)
      else $error("window one did not hand over to window two");
   a_fourth_new_win1: assert property (s_fourth_in_win2 |=>
      state_r == QAW_WIN1 && idx_r == QAW_IDX_FIRST)
      else $error("fourth byte did not open new window one");
   a_timeout_bad: assert property (s_win2_timeout |-> bad_end ##1 state_r == QAW_WIN1)
      else $error("window two timeout not counted bad");

   // Answer bookkeeping: faulty bytes, index steps, passive reads
   sequence s_faulty_byte;
      ans_wr && act && !ans_last && !bad_end && (!byte_ok || state_r == QAW_WIN2);
   endsequence

   a_fault_marked: assert property (s_faulty_byte |=> bad_r)
      else $error("faulty answer byte not marked");
   a_index_steps: assert property (ans_wr && act && !good_end && !bad_end |=>
      idx_r == $past(idx_r) - 2'h1)
      else $error("answer index did not step down");
   a_read_no_effect: assert property (q_read && !bad_end |=>
      question_r == $past(question_r) && idx_r == $past(idx_r))
      else $error("question read disturbed the cycle");

   // Cycle outcome: error count, failure flag, window hold
   a_early_fourth_bad: assert property ((state_r == QAW_WIN1) && ans_last && act |=>
      last_bad_r && question_r == $past(question_r))
      else $error("fourth byte in window one not counted bad");
   a_good_clean: assert property (good_end |=> !last_bad_r)
      else $error("good answer reported as bad");
   a_good_counts_down: assert property (good_end && err_r != 4'h0 |=>
      err_r == $past(err_r) - 4'h1)
      else $error("good answer did not lower error count");
   a_fire_sets_flag: assert property (fire && act_sel[0] |=> fail_flag_out)
      else $error("failure did not raise flag");
   a_fire_clears_err: assert property (fire |=> err_r == 4'h0)
      else $error("failure did not clear error count");
   a_win1_holds: assert property ((state_r == QAW_WIN1) && act && !window_end
      && !ans_last |=> state_r == QAW_WIN1)
      else $error("window one ended early");

endmodule : qaw_watchdog

/* rtl/qaw_pkg.sv */
package qaw_pkg;

   // Register offsets
   localparam logic [6:0] QAW_ADDR_SETUP_A = 7'h13;
   localparam logic [6:0] QAW_ADDR_SETUP_B = 7'h14;
   localparam logic [6:0] QAW_ADDR_KICK = 7'h15;
   localparam logic [6:0] QAW_ADDR_RST_WIDTH = 7'h16;
   localparam logic [6:0] QAW_ADDR_CHAL_SETUP = 7'h2d;
   localparam logic [6:0] QAW_ADDR_RESP_PORT = 7'h2e;
   localparam logic [6:0] QAW_ADDR_CHAL_VALUE = 7'h2f;

   // Field positions
   localparam int QAW_MODE_LSB = 6;
   localparam int QAW_PRE_LSB = 4;
   localparam int QAW_THR_LSB = 2;
   localparam int QAW_ACT_FLAG_BIT = 0;
   localparam int QAW_ACT_RST_BIT = 1;
   localparam int QAW_TIMER_LSB = 5;
   localparam int QAW_FRAME_RW_BIT = 15;
   localparam int QAW_FRAME_ADDR_LSB = 8;

   // Reset values
   localparam logic [7:0] QAW_SETUP_A_RST = 8'h00;
   localparam logic [2:0] QAW_TIMER_RST = 3'h0;
   localparam logic [7:0] QAW_RST_WIDTH_RST = 8'h00;
   localparam logic [7:0] QAW_CHAL_SETUP_RST = 8'h00;
   localparam logic [3:0] QAW_QUESTION_RST = 4'h0;
   localparam logic [1:0] QAW_IDX_FIRST = 2'h3;
   localparam logic [1:0] QAW_IDX_LAST = 2'h0;

   // Mode and failure thresholds
   localparam logic [1:0] QAW_MODE_QA = 2'h2;
   localparam logic [3:0] QAW_THR_1 = 4'h1;
   localparam logic [3:0] QAW_THR_5 = 4'h5;
   localparam logic [3:0] QAW_THR_9 = 4'h9;

   // Timing
   localparam int QAW_CLK_HZ = 25000000;
   localparam int QAW_MS_PER_S = 1000;
   localparam int QAW_CYCLES_PER_MS = QAW_CLK_HZ / QAW_MS_PER_S;

   // Total period in ms by [timer][prescale]; zero marks a reserved code
   localparam logic [14:0] QAW_PERIOD_MS [8][4] = '{
      '{15'd4, 15'd8, 15'd12, 15'd16},
      '{15'd32, 15'd64, 15'd96, 15'd128},
      '{15'd128, 15'd256, 15'd384, 15'd512},
      '{15'd256, 15'd384, 15'd512, 15'd768},
      '{15'd512, 15'd1024, 15'd1536, 15'd2048},
      '{15'd2048, 15'd4096, 15'd6144, 15'd8192},
      '{15'd10240, 15'd20240, 15'd0, 15'd0},
      '{15'd0, 15'd0, 15'd0, 15'd0}
   };

   // Expected bytes per question, packed {index3, index2, index1, index0}
   localparam logic [31:0] QAW_ANSWER_TABLE [16] = '{
      32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959,
      32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3,
      32'hd222dd2d, 32'h9d6d9262, 32'hc434cb3b, 32'h8b7b8474,
      32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe
   };

   typedef enum logic [1:0] {
      QAW_IDLE = 2'b00,
      QAW_WIN1 = 2'b01,
      QAW_WIN2 = 2'b10
   } qaw_state_t;

endpackage : qaw_pkg

/* rtl/qaw_spi_link.sv */
module qaw_spi_link
   import qaw_pkg::*;
(
   // Link pins
   input wire logic spi_sclk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_mosi_in,
   output logic spi_miso_out,
   // Link-domain reset, asserted from the core domain
   input wire logic link_rst_in,
   // Core side
   input wire logic [7:0] rdata_in,
   output logic [15:0] frame_out,
   output logic frame_done_out
);

   logic [3:0] bit_cnt_r;
   logic [14:0] shift_r;
   logic [7:0] out_r;
   logic frame_last;

   assign frame_last = (bit_cnt_r == 4'hf);
   assign spi_miso_out = out_r[7];

   // Bit counter and input shifter, cleared while chip select is high
   always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in) begin
      if (spi_cs_n_in) begin
         bit_cnt_r <= 4'h0;
         shift_r <= 15'h0000;
      end else begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         shift_r <= {shift_r[13:0], spi_mosi_in};
      end
   end

   // Frame holder and done level; done stays up until the next frame's first edge
   always_ff @(posedge spi_sclk_in or posedge link_rst_in) begin
      if (link_rst_in) begin
         frame_out <= 16'h0000;
         frame_done_out <= 1'b0;
      end else begin
         frame_done_out <= frame_last & ~spi_cs_n_in;
         if (frame_last && !spi_cs_n_in) begin
            frame_out <= {shift_r, spi_mosi_in};
         end
      end
   end

   // Output shifter: previous read result goes out in the data byte
   always_ff @(negedge spi_sclk_in or posedge spi_cs_n_in) begin
      if (spi_cs_n_in) begin
         out_r <= 8'h00;
      end else if (bit_cnt_r == 4'h8) begin
         out_r <= rdata_in;
      end else begin
         out_r <= {out_r[6:0], 1'b0};
      end
   end

endmodule : qaw_spi_link

/* verif/qaw_mcu_model.sv */
module qaw_mcu_model
   import qaw_pkg::*;
(
   // Link pins
   output logic spi_sclk_out,
   output logic spi_cs_n_out,
   output logic spi_mosi_out,
   input wire logic spi_miso_in
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF_NS = 16;
   localparam int GAP_NS = 240;

   // Link idles with clock still and select high
   initial begin
      spi_sclk_out = 1'b0;
      spi_cs_n_out = 1'b1;
      spi_mosi_out = 1'b0;
   end

   // One 16-bit frame, mode 0; returns the byte seen on bits 7:0
   task automatic xfer(input logic [15:0] frame, output logic [7:0] rx);
      rx = 8'h00;
      #7;
      spi_cs_n_out = 1'b0;
      for (int b = 15; b >= 0; b--) begin
         spi_mosi_out = frame[b];
         #HALF_NS;
         spi_sclk_out = 1'b1;
         if (b < 8) begin
            rx = {rx[6:0], spi_miso_in};
         end
         #HALF_NS;
         spi_sclk_out = 1'b0;
      end
      #HALF_NS;
      spi_cs_n_out = 1'b1;
      spi_mosi_out = ~spi_mosi_out; // Released line never shows the last bit
      #GAP_NS; // Gap above five core cycles
   endtask : xfer

   // Single-byte write frame
   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      logic [7:0] unused;
      xfer({1'b1, addr, data}, unused);
   endtask : wr

   // Read data comes back in the following frame
   task automatic rd(input logic [6:0] addr, output logic [7:0] data);
      logic [7:0] unused;
      xfer({1'b0, addr, 8'h00}, unused);
      xfer({1'b0, QAW_ADDR_SETUP_A, 8'h00}, data);
   endtask : rd
endmodule : qaw_mcu_model

/* verif/testbench.sv */
module testbench
   import qaw_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CPM = 4;
   localparam int WIN = 64 * CPM; // Half of the 128 ms period
   localparam int LIMIT = 40000;
   localparam int RW = 5; // Failure reset width in ms
   logic clk_in, srst_in, ce_in, sclk, cs_n, mosi, miso, flag, rst, bad_m;
   int err_count, tests_run, cyc, t_win, rst_hi, err_m, thr_m;
   logic [3:0] q_m;
   logic [7:0] got, rnd;
   logic [6:0] ra [8] = '{7'h13, 7'h14, 7'h16, 7'h2d, 7'h2f, 7'h15, 7'h2e, 7'h7f};
   logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
   int bk [5] = '{3, 1, -1, -1, 0};
   int bl [5] = '{WIN, WIN, -1, 0, WIN};

   // Device and controller model
   qaw_watchdog #(.CYCLES_PER_MS(CPM)) dut (.clk_in(clk_in), .srst_in(srst_in),
      .ce_in(ce_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
      .spi_miso_out(miso), .fail_flag_out(flag), .fail_reset_out(rst));
   qaw_mcu_model mcu (.spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi),
      .spi_miso_in(miso));

   // Core clock
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // Reset pulse length, sampled away from the launching edge
   always @(negedge clk_in) begin
      if (rst === 1'b1) begin
         rst_hi <= rst_hi + 1;
      end
   end

   // Cycle count and hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         results();
      end
   end

   // Next question of the chain
   function automatic logic [3:0] nq(input logic [3:0] q);
      return (q == 4'h0) ? 4'h1 : {q[2:0], q[3] ^ q[2]};
   endfunction : nq

   // Comparisons
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk8
   task automatic chk1(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
         err_count++;
      end
   endtask : chk1

   // Verdict
   task automatic results();
      $display("tests_run %0d err_count %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   // Question, index and error count against the bench model
   task automatic chk_state(input string nm);
      mcu.rd(QAW_ADDR_CHAL_VALUE, got);
      chk8(nm, {bad_m, 1'b0, QAW_IDX_FIRST, q_m}, got);
      mcu.rd(QAW_ADDR_SETUP_B, got);
      chk8(nm, {3'h1, 1'b0, err_m[3:0]}, got);
   endtask : chk_state

   // One question cycle: bad picks a wrong byte, late the last byte's moment
   task automatic qa(input bit rdq, input int bad, input int late);
      logic [7:0] b;
      if (rdq) begin
         mcu.xfer({1'b0, QAW_ADDR_CHAL_VALUE, 8'h00}, got);
         t_win = cyc;
      end
      for (int i = 3; i >= 0; i--) begin
         b = QAW_ANSWER_TABLE[q_m][i*8 +: 8];
         b = b ^ ((bad == i) ? 8'(($urandom % 255) + 1) : 8'h00);
         if (i == 0) begin
            while (cyc < t_win + ((late < 0) ? 2 * WIN : late) + 16) begin
               @(negedge clk_in);
            end
         end
         if (i > 0 || late >= 0) begin
            mcu.wr(QAW_ADDR_RESP_PORT, b);
         end
         if (i == 3) begin
            mcu.rd(QAW_ADDR_CHAL_VALUE, got);
            chk8("index after first byte", {bad_m, 1'b0, 2'h2, q_m}, got);
         end
      end
      t_win = cyc;
      if (bad < 0 && late == WIN) begin
         err_m = (err_m > 0) ? err_m - 1 : 0;
         q_m = nq(q_m);
      end else begin
         err_m = (err_m + 1 >= thr_m) ? 0 : err_m + 1; // Failure clears the count
      end
      bad_m = !(bad < 0 && late == WIN);
   endtask : qa

   // Main sequence
   initial begin
      srst_in = 1'b1;
      ce_in = 1'b1;
      q_m = QAW_QUESTION_RST;
      bad_m = 1'b0;
      thr_m = 5;
      void'($urandom(32'h11ce1292));
      repeat (4) @(negedge clk_in);
      srst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      chk1("fail flag", 1'b0, flag);
      chk1("fail reset", 1'b0, rst);
      mcu.wr(QAW_ADDR_CHAL_VALUE, 8'($urandom));
      foreach (ra[k]) begin
         mcu.rd(ra[k], got);
         chk8("reset value", rv[k], got);
      end
      for (int k = 0; k < 2; k++) begin
         rnd = 8'($urandom);
         mcu.wr(k ? QAW_ADDR_RST_WIDTH : QAW_ADDR_CHAL_SETUP, rnd);
         mcu.rd(k ? QAW_ADDR_RST_WIDTH : QAW_ADDR_CHAL_SETUP, got);
         chk8("rw store", rnd, got);
      end
      mcu.wr(QAW_ADDR_RST_WIDTH, 8'(RW));
      mcu.wr(QAW_ADDR_SETUP_B, 8'h20);
      mcu.wr(QAW_ADDR_SETUP_A, 8'hb7);
      mcu.rd(QAW_ADDR_SETUP_A, got);
      chk8("setup a", 8'hb7, got);
      $display("test registers done");
      // Timer stays off until the question is read
      repeat (3 * WIN) @(negedge clk_in);
      mcu.rd(QAW_ADDR_SETUP_B, got);
      chk8("idle error count", 8'h20, got);
      qa(1'b1, -1, WIN);
      chk_state("good with read");
      qa(1'b0, -1, WIN);
      chk_state("good without read");
      $display("test good cycles done");
      // Five kinds of bad cycle up to the failure threshold
      foreach (bk[k]) begin
         rst_hi = 0;
         qa(1'b0, bk[k], bl[k]);
         chk_state("bad cycle");
         chk1("fail flag", k == 4, flag);
         chk1("reset pulse", k == 4, rst_hi >= (RW - 1) * CPM && rst_hi <= RW * CPM + 1);
      end
      $display("test bad cycles done");
      for (int k = 0; k < 3; k++) begin
         qa(1'b0, (k == 1) ? 2 : -1, WIN);
         chk_state("recovery");
      end
      mcu.wr(QAW_ADDR_KICK, 8'($urandom));
      chk1("fail flag after kick", 1'b0, flag);
      mcu.rd(QAW_ADDR_CHAL_VALUE, got);
      chk8("index after kick", {2'h0, QAW_IDX_FIRST, q_m}, got & 8'h3f);
      $display("test kick done");
      // Frame arriving while the enable is low is lost
      @(negedge clk_in);
      ce_in = 1'b0;
      mcu.wr(QAW_ADDR_SETUP_A, 8'h00);
      @(negedge clk_in);
      ce_in = 1'b1;
      mcu.rd(QAW_ADDR_SETUP_A, got);
      chk8("frozen setup a", 8'hb7, got);
      $display("test enable done");
      // Threshold of one with the flag action only
      mcu.wr(QAW_ADDR_SETUP_A, 8'hb1);
      thr_m = 1;
      rst_hi = 0;
      qa(1'b1, 2, WIN);
      chk_state("threshold one");
      chk1("flag only action", 1'b1, flag);
      chk1("no reset action", 1'b0, rst_hi != 0);
      $display("test threshold done");
      results();
   end
endmodule : testbench
